// ### hdl/scd_pkg.sv
// shared constants, types and helpers of the system clock divider
package scd_pkg;

	// *****************************
	// register location and layout
	// *****************************
	localparam logic [7:0] SFR_ADDR = 8'hC7;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int MODE_LSB = 4;
	localparam int MODE_MSB = 5;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 2;

	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_IMMEDIATE = 2'h1;
	localparam logic [1:0] MODE_DELAY = 2'h2;
	localparam logic [1:0] MODE_MANUAL = 2'h3;
	localparam logic [2:0] SEL_RESET = 3'h0;

	// *****************************
	// divider terminal counts (divisor minus one)
	// *****************************
	localparam int CNT_W = 12;
	localparam logic [11:0] TERM_DIV2 = 12'h001;
	localparam logic [11:0] TERM_DIV4 = 12'h003;
	localparam logic [11:0] TERM_DIV8 = 12'h007;
	localparam logic [11:0] TERM_DIV16 = 12'h00F;
	localparam logic [11:0] TERM_DIV32 = 12'h01F;
	localparam logic [11:0] TERM_DIV1024 = 12'h3FF;
	localparam logic [11:0] TERM_DIV2048 = 12'h7FF;
	localparam logic [11:0] TERM_DIV4096 = 12'hFFF;

	// *****************************
	// types
	// *****************************
	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_IMMEDIATE,
		ST_DELAY_WAIT,
		ST_DELAY_DIV,
		ST_DELAY_WOKE,
		ST_MANUAL
	} scd_state_e;

	typedef struct packed {
		logic aux_pending;
		logic watchdog;
		logic ext1;
		logic ext0;
	} scd_wake_s;

	typedef struct packed {
		logic active;
		logic [2:0] sel;
	} scd_cfg_s;

	function automatic logic [11:0] term_count(input logic [2:0] sel);
		case (sel)
			3'h0: term_count = TERM_DIV2;
			3'h1: term_count = TERM_DIV4;
			3'h2: term_count = TERM_DIV8;
			3'h3: term_count = TERM_DIV16;
			3'h4: term_count = TERM_DIV32;
			3'h5: term_count = TERM_DIV1024;
			3'h6: term_count = TERM_DIV2048;
			default: term_count = TERM_DIV4096;
		endcase
	endfunction

endpackage

// ### hdl/scd_tick_gen.sv
// clock enable generator that applies a new divisor only at a period boundary
`timescale 1ns/10ps
`default_nettype none
module scd_tick_gen (
	input wire logic clock,
	input wire logic rst,
	input wire scd_pkg::scd_cfg_s cfg_req,
	output logic clk_en,
	output scd_pkg::scd_cfg_s cfg_applied
);

	logic [11:0] cnt;
	logic boundary;

	// *****************************
	// period counter
	// *****************************
	// settings only change at the end of a whole period, so no shortened pulse
	assign boundary = !cfg_applied.active || (cnt == scd_pkg::term_count(cfg_applied.sel));

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt <= 12'h000;
			cfg_applied <= '0;
		end else if (boundary) begin
			cnt <= 12'h000;
			cfg_applied <= cfg_req;
		end else begin
			cnt <= cnt + 12'h001;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			clk_en <= 1'b1;
		end else begin
			clk_en <= boundary;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	chk_undivided_every_cycle: assert property (!cfg_applied.active |=> clk_en) else $error("undivided enable missed");
	chk_divided_quiet_gap: assert property (cfg_applied.active
		&& cnt != scd_pkg::term_count(cfg_applied.sel)
		|=> !clk_en && $stable(cfg_applied)) else $error("enable or setting changed mid period");
	chk_div2_period: assert property (cfg_applied.active && cfg_applied.sel == 3'h0 && cnt == 12'h000
		|=> !clk_en ##1 clk_en) else $error("divide by two period wrong");

endmodule
`default_nettype wire

// ### hdl/scd_top.sv
// system clock divider: divider register, divide mode sequencing and internal clock enable
//
// Behaviour
// - mode 00 passes the system clock undivided and is the reset state.
// - mode 01 divides at once and returns to undivided on an idle wakeup or a register write.
// - mode 10 with the millisecond interrupt enabled divides from the next tick to the one after.
// - mode 10 with that interrupt masked divides from the next tick until the tick after a wakeup.
// - mode 11 divides at once and only a register write ends it.
// - reading the mode field gives the mode actually in force, including automatic returns.
// - divisor codes 000 to 111 select 2, 4, 8, 16, 32, 1024, 2048 and 4096.
// - the divided enable drives every internal clock domain.
// - wakeups are enabled auxiliary interrupts plus watchdog and external sources picked by wake enables.
`timescale 1ns/10ps
`default_nettype none
module scd_top (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic ms_tick,
	input wire logic millisecond_tick_interrupt,
	input wire logic aux_interrupt_enable,
	input wire logic [2:0] idle_wake_enable,
	input wire scd_pkg::scd_wake_s wake_src,
	output logic int_clk_en,
	output logic divide_active
);

	scd_pkg::scd_state_e state;
	scd_pkg::scd_state_e next_state;
	scd_pkg::scd_cfg_s cfg_req;
	scd_pkg::scd_cfg_s cfg_applied;
	logic [2:0] div_sel;
	logic [1:0] mode_now;
	logic reg_wr;
	logic reg_rd;
	logic wake;
	logic tick_en;

	// *****************************
	// register access
	// *****************************
	assign reg_wr = sfr_wr && (sfr_addr == scd_pkg::SFR_ADDR);
	assign reg_rd = sfr_rd && (sfr_addr == scd_pkg::SFR_ADDR);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_sel <= scd_pkg::SEL_RESET;
		end else if (reg_wr) begin
			div_sel <= sfr_wdata[scd_pkg::SEL_MSB:scd_pkg::SEL_LSB];
		end
	end

	function automatic logic [1:0] mode_of(input scd_pkg::scd_state_e st);
		case (st)
			scd_pkg::ST_IMMEDIATE: mode_of = scd_pkg::MODE_IMMEDIATE;
			scd_pkg::ST_DELAY_WAIT, scd_pkg::ST_DELAY_DIV, scd_pkg::ST_DELAY_WOKE: mode_of = scd_pkg::MODE_DELAY;
			scd_pkg::ST_MANUAL: mode_of = scd_pkg::MODE_MANUAL;
			default: mode_of = scd_pkg::MODE_NORMAL;
		endcase
	endfunction

	assign mode_now = mode_of(state);

	// read data is held until the next read of any kind
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sfr_rdata <= scd_pkg::REG_RESET;
		end else if (reg_rd) begin
			sfr_rdata <= {2'h0, mode_now, 1'h0, div_sel};
		end else if (sfr_rd) begin
			sfr_rdata <= 8'h00;
		end
	end

	// *****************************
	// wakeup sources
	// *****************************
	assign wake = (aux_interrupt_enable && wake_src.aux_pending)
		|| (idle_wake_enable[2] && wake_src.watchdog)
		|| (idle_wake_enable[1] && wake_src.ext1)
		|| (idle_wake_enable[0] && wake_src.ext0);

	// *****************************
	// divide mode sequencing
	// *****************************
	// a register write always wins over a tick or wakeup in the same cycle
	always_comb begin
		next_state = state;
		if (reg_wr) begin
			case (sfr_wdata[scd_pkg::MODE_MSB:scd_pkg::MODE_LSB])
				scd_pkg::MODE_IMMEDIATE: next_state = scd_pkg::ST_IMMEDIATE;
				scd_pkg::MODE_DELAY: next_state = scd_pkg::ST_DELAY_WAIT;
				scd_pkg::MODE_MANUAL: next_state = scd_pkg::ST_MANUAL;
				default: next_state = scd_pkg::ST_NORMAL;
			endcase
		end else begin
			case (state)
				scd_pkg::ST_IMMEDIATE: begin
					if (wake) begin
						next_state = scd_pkg::ST_NORMAL;
					end
				end
				scd_pkg::ST_DELAY_WAIT: begin
					if (ms_tick) begin
						next_state = scd_pkg::ST_DELAY_DIV;
					end
				end
				scd_pkg::ST_DELAY_DIV: begin
					if (ms_tick && millisecond_tick_interrupt) begin
						next_state = scd_pkg::ST_NORMAL;
					end else if (wake && !millisecond_tick_interrupt) begin
						next_state = scd_pkg::ST_DELAY_WOKE;
					end
				end
				scd_pkg::ST_DELAY_WOKE: begin
					if (ms_tick) begin
						next_state = scd_pkg::ST_NORMAL;
					end
				end
				default: next_state = state;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= scd_pkg::ST_NORMAL;
		end else begin
			state <= next_state;
		end
	end

	assign cfg_req = '{
		active: (state == scd_pkg::ST_IMMEDIATE) || (state == scd_pkg::ST_DELAY_DIV)
			|| (state == scd_pkg::ST_DELAY_WOKE) || (state == scd_pkg::ST_MANUAL),
		sel: div_sel
	};

	// *****************************
	// internal clock enable
	// *****************************
	scd_tick_gen u_tick_gen (
		.clock(clock),
		.rst(rst),
		.cfg_req(cfg_req),
		.clk_en(tick_en),
		.cfg_applied(cfg_applied)
	);

	// one enable feeds every internal domain, so a divider change moves them all together
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			int_clk_en <= 1'b1;
			divide_active <= 1'b0;
		end else begin
			int_clk_en <= tick_en;
			divide_active <= cfg_applied.active;
		end
	end

	// *****************************
	// checks
	// *****************************
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	chk_write_normal_mode: assert property (reg_wr && sfr_wdata[5:4] == 2'h0
		|=> state == scd_pkg::ST_NORMAL && !cfg_req.active) else $error("mode 00 write did not stop division");
	chk_write_delay_mode: assert property (reg_wr && sfr_wdata[5:4] == 2'h2
		|=> state == scd_pkg::ST_DELAY_WAIT) else $error("mode 10 write did not arm delay mode");
	chk_write_manual_mode: assert property (reg_wr && sfr_wdata[5:4] == 2'h3
		|=> state == scd_pkg::ST_MANUAL && cfg_req.active) else $error("mode 11 write did not start division");
	chk_write_divisor: assert property (reg_wr
		|=> div_sel == $past(sfr_wdata[2:0])) else $error("divisor write not taken");
	chk_normal_no_request: assert property (state == scd_pkg::ST_NORMAL
		|-> !cfg_req.active) else $error("normal mode requested division");

	// *****************************
	// immediate and manual mode checks
	// *****************************
	chk_immediate_start: assert property (reg_wr && sfr_wdata[5:4] == 2'h1
		|=> cfg_req.active ##2 divide_active || !$past(cfg_req.active)) else $error("immediate mode did not start");
	chk_immediate_wake_exit: assert property (state == scd_pkg::ST_IMMEDIATE && wake
		&& !reg_wr |=> mode_now == 2'h0) else $error("wakeup did not end immediate mode");
	chk_manual_holds: assert property (state == scd_pkg::ST_MANUAL && !reg_wr
		|=> state == scd_pkg::ST_MANUAL) else $error("manual mode left without a write");

	// *****************************
	// delay mode checks
	// *****************************
	// the tick starts division whether or not its interrupt is masked
	chk_delay_waits_tick: assert property (state == scd_pkg::ST_DELAY_WAIT && !ms_tick
		&& !reg_wr |=> !cfg_req.active && mode_now == 2'h2) else $error("delay mode divided before tick");
	chk_delay_tick_start: assert property (state == scd_pkg::ST_DELAY_WAIT && ms_tick
		&& !reg_wr
		|=> state == scd_pkg::ST_DELAY_DIV && cfg_req.active) else $error("tick did not start delay division");
	chk_delay_enabled_end: assert property (state == scd_pkg::ST_DELAY_DIV && ms_tick
		&& millisecond_tick_interrupt && !reg_wr
		|=> state == scd_pkg::ST_NORMAL) else $error("enabled tick did not end delay mode");
	chk_delay_masked_hold: assert property (state == scd_pkg::ST_DELAY_DIV
		&& !millisecond_tick_interrupt && !wake && !reg_wr
		|=> cfg_req.active) else $error("masked delay mode ended early");
	chk_masked_wake_seen: assert property (state == scd_pkg::ST_DELAY_DIV && wake
		&& !millisecond_tick_interrupt && !reg_wr
		|=> state == scd_pkg::ST_DELAY_WOKE) else $error("wakeup not noted in masked delay mode");
	chk_woke_holds: assert property (state == scd_pkg::ST_DELAY_WOKE && !ms_tick && !reg_wr
		|=> cfg_req.active && mode_now == 2'h2) else $error("woken delay mode ended before tick");
	chk_woke_tick_end: assert property (state == scd_pkg::ST_DELAY_WOKE && ms_tick && !reg_wr
		|=> mode_now == 2'h0) else $error("tick after wakeup did not end delay mode");

	// *****************************
	// read data and enable output checks
	// *****************************
	chk_read_mode_field: assert property (reg_rd
		|=> sfr_rdata[5:4] == mode_of($past(state)) && sfr_rdata[2:0] == $past(div_sel))
		else $error("mode read wrong");
	chk_reserved_zero: assert property (reg_rd |=> sfr_rdata[7:6] == 2'h0 && !sfr_rdata[3]) else $error("reserved bits set");
	// another address leaves nothing of this register on the read bus
	chk_foreign_read_zero: assert property (sfr_rd && !reg_rd
		|=> sfr_rdata == 8'h00) else $error("foreign read not zero");
	chk_enable_follows: assert property (tick_en |=> int_clk_en) else $error("internal enable lost");
	chk_enable_drop: assert property (!tick_en |=> !int_clk_en) else $error("internal enable stuck high");
	chk_active_flag: assert property (divide_active == $past(cfg_applied.active))
		else $error("divide flag lags");

endmodule
`default_nettype wire

// ### tb/scd_tb_top.sv
// self-checking bench of the system clock divider
`timescale 1ns/10ps
`default_nettype none
module system_clock_divider_tb_top;
	logic clock, rst, sfr_wr, sfr_rd, ms_tick, millisecond_tick_interrupt, aux_interrupt_enable;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic [2:0] idle_wake_enable;
	scd_pkg::scd_wake_s wake_src;
	logic int_clk_en, divide_active;
	int failures = 0;
	int num_checks = 0;
	int model_mode;
	int model_sel;
	int pick;

	scd_top u_dut (.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .ms_tick(ms_tick),
		.millisecond_tick_interrupt(millisecond_tick_interrupt), .aux_interrupt_enable(aux_interrupt_enable),
		.idle_wake_enable(idle_wake_enable), .wake_src(wake_src), .int_clk_en(int_clk_en),
		.divide_active(divide_active));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// *****************************
	// shared tasks, all entered and left at a falling edge
	// *****************************
	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		sfr_addr = addr;
		sfr_wdata = data;
		sfr_wr = 1'b1;
		@(negedge clock);
		sfr_wr = 1'b0;
		if (addr == scd_pkg::SFR_ADDR) begin
			model_mode = int'(data[5:4]);
			model_sel = int'(data[2:0]);
		end
	endtask

	task automatic check_read(input logic [7:0] addr);
		logic [7:0] exp;
		sfr_addr = addr;
		sfr_rd = 1'b1;
		@(negedge clock);
		sfr_rd = 1'b0;
		exp = (addr == scd_pkg::SFR_ADDR) ? {2'b00, 2'(model_mode), 1'b0, 3'(model_sel)} : 8'h00;
		chk("register read", 16'(exp), 16'(sfr_rdata));
	endtask

	// the first pulses may still close a period of the old setting, so only the third gap counts
	task automatic check_period(input int exp_n);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(negedge clock);
				n++;
			end while (int_clk_en !== 1'b1 && n < 9000);
			if (n >= 9000) begin
				failures++;
				$display("CHECK FAILED clock enable pulse expected within 9000 seen none");
				stop_test();
			end
		end
		chk("enable period", 16'(exp_n), 16'(n));
	endtask

	task automatic pulse_wake(input int i);
		wake_src = scd_pkg::scd_wake_s'(4'(1 << i));
		@(negedge clock);
		wake_src = '0;
		@(negedge clock);
	endtask

	task automatic pulse_tick();
		ms_tick = 1'b1;
		@(negedge clock);
		ms_tick = 1'b0;
		repeat (2) @(negedge clock);
	endtask

	// *****************************
	// main sequence
	// *****************************
	initial begin
		rst = 1'b1;
		{sfr_wr, sfr_rd, ms_tick, millisecond_tick_interrupt, aux_interrupt_enable} = 5'h00;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		idle_wake_enable = 3'h0;
		wake_src = '0;
		model_mode = 0;
		model_sel = 0;
		void'($urandom(83582));
		repeat (3) @(negedge clock);
		rst = 1'b0;
		check_read(scd_pkg::SFR_ADDR);
		check_period(1);
		chk("divide active", 16'h0000, 16'(divide_active));
		$display("test reset done");
		for (int c = 0; c < 8; c++) begin
			reg_write(scd_pkg::SFR_ADDR, 8'hF8 | 8'(c));
			check_read(scd_pkg::SFR_ADDR);
			check_period(c < 5 ? 2 << c : 1024 << (c - 5));
			chk("divide active", 16'h0001, 16'(divide_active));
		end
		reg_write(scd_pkg::SFR_ADDR, 8'h30);
		{aux_interrupt_enable, idle_wake_enable} = 4'hF;
		for (int i = 0; i < 4; i++) pulse_wake(i);
		check_read(scd_pkg::SFR_ADDR);
		$display("test manual done");
		reg_write(scd_pkg::SFR_ADDR, 8'($urandom) & 8'hCF);
		check_read(scd_pkg::SFR_ADDR);
		check_period(1);
		chk("divide active", 16'h0000, 16'(divide_active));
		$display("test normal write done");
		reg_write(scd_pkg::SFR_ADDR, 8'h11);
		check_read(scd_pkg::SFR_ADDR);
		check_period(4);
		{aux_interrupt_enable, idle_wake_enable} = 4'h0;
		pulse_wake($urandom_range(3, 0));
		check_read(scd_pkg::SFR_ADDR);
		pick = $urandom_range(3, 0);
		{aux_interrupt_enable, idle_wake_enable} = 4'(1 << pick);
		pulse_wake(pick);
		model_mode = 0;
		check_read(scd_pkg::SFR_ADDR);
		check_period(1);
		$display("test immediate done");
		millisecond_tick_interrupt = 1'b1;
		reg_write(scd_pkg::SFR_ADDR, 8'h20);
		repeat (4) @(negedge clock);
		chk("divide active", 16'h0000, 16'(divide_active));
		check_read(scd_pkg::SFR_ADDR);
		pulse_tick();
		check_period(2);
		check_read(scd_pkg::SFR_ADDR);
		pulse_tick();
		model_mode = 0;
		check_read(scd_pkg::SFR_ADDR);
		check_period(1);
		millisecond_tick_interrupt = 1'b0;
		reg_write(scd_pkg::SFR_ADDR, 8'h21);
		pulse_tick();
		check_period(4);
		pulse_tick();
		check_read(scd_pkg::SFR_ADDR);
		chk("divide active", 16'h0001, 16'(divide_active));
		pulse_wake(pick);
		check_read(scd_pkg::SFR_ADDR);
		pulse_tick();
		model_mode = 0;
		check_read(scd_pkg::SFR_ADDR);
		check_period(1);
		$display("test delay done");
		reg_write(8'hC6, 8'h31);
		check_read(scd_pkg::SFR_ADDR);
		@(negedge clock);
		check_read(8'hC6);
		check_period(1);
		$display("test foreign address done");
		stop_test();
	end
endmodule
`default_nettype wire
